// File: pkg/ccc_pkg.sv
package ccc_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] RISE_CH2_OFFSET = 8'h04;
    localparam logic [7:0] FALL_CH2_OFFSET = 8'h08;
    localparam logic [7:0] RISE_CH3_OFFSET = 8'h0C;
    localparam logic [7:0] FALL_CH3_OFFSET = 8'h10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] SNAP_RESET = 16'h0000;

    // ----------------------------------------
    // field positions, channel base 0 or 16
    // ----------------------------------------
    localparam int CH2_BASE = 0;
    localparam int CH3_BASE = 16;
    localparam int POL_BIT = 0;
    localparam int RIE_BIT = 1;
    localparam int FIE_BIT = 2;
    localparam int CEN_BIT = 3;
    localparam int IRQF_BIT = 4;
    localparam int RLAT_BIT = 6;
    localparam int FLAT_BIT = 7;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic fall_latched;
        logic rise_latched;
        logic irq_flag;
        logic capture_enable;
        logic fall_irq_en;
        logic rise_irq_en;
        logic polarity_flip;
    } ccc_chan_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ccc_bus_type;

endpackage

// File: sim/ccc_capture_asserts.sv
`timescale 1ns/10ps
module ccc_capture_asserts (
    // clock
    input wire logic CLOCK,
    input wire logic RESET,
    // bus
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    // capture
    input wire logic [1:0] CAPTURE_IRQ_FLAG,
    input wire logic [1:0] CAPTURE_IRQ
);
    wire [1:0] clr = {WDATA[20], WDATA[4]} & {2{WR && ADDR == ccc_pkg::CTRL_OFFSET}};
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    chk_read_idle: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
        else $error("rdata not idle");
    chk_snap_upper: assert property ($past(RD) && $past(ADDR) != 8'h00 |-> RDATA[31:16] == 16'h0000)
        else $error("snapshot upper set");
    chk_ctrl_rsvd: assert property ($past(RD) && $past(ADDR) == 8'h00 |-> !(RDATA & 32'hFF20_FF20))
        else $error("reserved set");
    chk_flag_read: assert property (RD && ADDR == 8'h00 |=> {RDATA[20], RDATA[4]} == CAPTURE_IRQ_FLAG)
        else $error("flag mismatch");
    chk_irq_ch2: assert property ($rose(CAPTURE_IRQ[0]) |-> CAPTURE_IRQ_FLAG[0])
        else $error("irq without flag");
    chk_irq_ch3: assert property ($rose(CAPTURE_IRQ[1]) |-> CAPTURE_IRQ_FLAG[1])
        else $error("irq without flag");
    chk_clear_ch2: assert property ($fell(CAPTURE_IRQ_FLAG[0]) |-> $past(clr, 2) & 2'b01)
        else $error("flag lost");
    chk_clear_ch3: assert property ($fell(CAPTURE_IRQ_FLAG[1]) |-> $past(clr, 2) & 2'b10)
        else $error("flag lost");
    cov_irq_ch2: cover property ($rose(CAPTURE_IRQ[0]));
    cov_irq_ch3: cover property ($rose(CAPTURE_IRQ[1]));
    cov_clear: cover property ($fell(CAPTURE_IRQ_FLAG[0]));
endmodule
bind ccc_capture ccc_capture_asserts u_asserts (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CAPTURE_IRQ_FLAG(CAPTURE_IRQ_FLAG), .CAPTURE_IRQ(CAPTURE_IRQ));

// File: sim/ccc_pin_model.sv
`timescale 1ns/10ps
module ccc_pin_model (
    // request
    input wire logic [1:0] level,
    // pin
    output logic [1:0] pin
);
    initial pin = 2'h0;
    // pin moves off the clock edge
    always @(level) pin <= #3 level;
endmodule

// File: sim/tb.sv
`timescale 1ns/10ps
module tb;
    logic CLOCK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, FLAG_CLEAR_POLARITY = 1'b0, pol, f;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000, ctrl = 32'h0000_0000, RDATA, cfg, lat;
    logic [15:0] COUNTER = 16'h0000, cnt, snap [4] = '{default: 16'h0000};
    logic [1:0] lvl = 2'h0, CAPTURE_PIN, CAPTURE_IRQ_FLAG, CAPTURE_IRQ, irq_seen;
    int fails = 0, checks = 0, c;
    ccc_pin_model u_pin (.level(lvl), .pin(CAPTURE_PIN));
    ccc_capture DUT (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .COUNTER(COUNTER), .FLAG_CLEAR_POLARITY(FLAG_CLEAR_POLARITY), .CAPTURE_PIN(CAPTURE_PIN),
        .CAPTURE_IRQ_FLAG(CAPTURE_IRQ_FLAG), .CAPTURE_IRQ(CAPTURE_IRQ));
    initial forever #5 CLOCK = ~CLOCK;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        @(negedge CLOCK);
        check(RDATA, exp);
        @(posedge CLOCK);
    endtask
    task automatic end_sim();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLOCK);
        fails++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h09c6));
        repeat (3) @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
        rd(8'h14, 32'h0000_0000);
        for (int i = 0; i < 40; i++) begin
            cfg = (i == 0) ? 32'h000E_000E : $urandom & 32'h000F_000F;
            pol = 1'($urandom);
            FLAG_CLEAR_POLARITY <= pol;
            lat = {2{8'h00, pol, pol, 6'h00}};
            wr(8'h00, cfg & 32'h0007_0007 | ~lat & 32'h00C0_00C0 | $urandom & 32'hFF20_FF20);
            ctrl = ctrl & 32'h00D0_00D0 | cfg & 32'h0007_0007;
            repeat (8) @(posedge CLOCK);
            rd(8'h00, ctrl);
            wr(8'h00, cfg | lat | 32'h0010_0010);
            wr(ccc_pkg::RISE_CH2_OFFSET, $urandom);
            ctrl = cfg;
            c = $urandom % 2;
            cnt = 16'($urandom);
            f = lvl[c] ^ cfg[16*c];
            COUNTER <= cnt;
            lvl[c] <= ~lvl[c];
            if (cfg[16*c+3]) begin
                snap[2*c+f] = cnt;
                ctrl[16*c+6+f] = 1'b1;
                ctrl[16*c+4] = cfg[16*c+1+f];
            end
            irq_seen = 2'h0;
            repeat (8) begin
                @(negedge CLOCK);
                irq_seen = irq_seen | CAPTURE_IRQ;
            end
            check(32'(CAPTURE_IRQ_FLAG), 32'({ctrl[20], ctrl[4]}));
            check(32'(irq_seen), 32'({ctrl[20], ctrl[4]}));
            @(posedge CLOCK);
            rd(8'h00, ctrl);
            for (int k = 0; k < 4; k++) rd(ccc_pkg::RISE_CH2_OFFSET + 8'(4 * k), 32'(snap[k]));
        end
        end_sim();
    end
endmodule

// File: src/ccc_capture.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
// Contract
// R1: ch3 rising edge with enable raises interrupt
// R2: polarity flip bit inverts pin input
// R3: ch2 fall loads fall snapshot, sets flag
// R4: ch2 rise loads rise snapshot, sets flag
// R5: latched flag cleared per clear polarity
// R6: ch2 rise sets irq flag if enabled
// R7: ch2 fall sets irq flag if enabled
// R8: write one clears irq flag
// R9: capture enable allows snapshot latching
// R10: capture disabled blocks snapshots and interrupt
// R11: ch2 falling interrupt enable gates interrupt
// R12: ch2 rising interrupt enable gates interrupt
// R13: ch3 irq flag set per edge enables
// R14: ch3 capture enable gates like ch2
// R15: ch3 edges latch snapshot and flags
// R16: snapshots 16 bit, read only, upper zero
// R17: ch3 falling enable gates falling interrupt
// R18: reserved control bits read zero
module ccc_capture #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // timer side
    input wire logic [CNT_W-1:0] COUNTER,
    input wire logic FLAG_CLEAR_POLARITY,
    input wire logic [1:0] CAPTURE_PIN,
    // capture flags
    output logic [1:0] CAPTURE_IRQ_FLAG,
    output logic [1:0] CAPTURE_IRQ
);

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    ccc_pkg::ccc_bus_type bus;
    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    wire ctrl_wr = bus.wr && (bus.addr == ccc_pkg::CTRL_OFFSET);

    ccc_pkg::ccc_chan_type chan_reg [2];
    logic [CNT_W-1:0] rise_snapshot_reg [2];
    logic [CNT_W-1:0] fall_snapshot_reg [2];
    wire [31:0] ctrl_view;
    logic [1:0] irq_reg;

    // ----------------------------------------
    // per channel capture
    // ----------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_ch
        localparam int B = (c == 0) ? ccc_pkg::CH2_BASE : ccc_pkg::CH3_BASE;
        logic [2:0] sync_reg;
        logic last_reg;
        ccc_pkg::ccc_chan_type ch_next;

        // three stage sync, level counts when stages two and three agree
        always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) begin
                sync_reg <= 3'h0;
            end else begin
                sync_reg <= {sync_reg[1:0], CAPTURE_PIN[c]};
            end
        end
        wire agree = (sync_reg[1] == sync_reg[2]);
        wire level = sync_reg[2] ^ chan_reg[c].polarity_flip; // R2
        always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) begin
                last_reg <= 1'b0;
            end else if (agree) begin
                last_reg <= level;
            end
        end
        wire en = chan_reg[c].capture_enable; // R10 R14
        wire rise = agree && en && level && !last_reg; // R9
        wire fall = agree && en && !level && last_reg; // R9
        wire rise_irq = rise && chan_reg[c].rise_irq_en; // R1 R12
        wire fall_irq = fall && chan_reg[c].fall_irq_en; // R11 R17

        wire [31:0] wd = bus.wdata;
        wire cp = FLAG_CLEAR_POLARITY;
        wire clr_r = ctrl_wr && (wd[B + ccc_pkg::RLAT_BIT] == cp); // R5
        wire clr_f = ctrl_wr && (wd[B + ccc_pkg::FLAT_BIT] == cp); // R5
        wire clr_i = ctrl_wr && wd[B + ccc_pkg::IRQF_BIT]; // R8

        always_comb begin
            ch_next = chan_reg[c];
            if (ctrl_wr) begin
                ch_next.polarity_flip = wd[B + ccc_pkg::POL_BIT];
                ch_next.rise_irq_en = wd[B + ccc_pkg::RIE_BIT];
                ch_next.fall_irq_en = wd[B + ccc_pkg::FIE_BIT];
                ch_next.capture_enable = wd[B + ccc_pkg::CEN_BIT];
            end
            // set wins over clear
            ch_next.rise_latched = rise || (chan_reg[c].rise_latched && !clr_r); // R4 R15
            ch_next.fall_latched = fall || (chan_reg[c].fall_latched && !clr_f); // R3 R15
            ch_next.irq_flag = rise_irq || fall_irq || (chan_reg[c].irq_flag && !clr_i); // R6 R7 R13
        end

        always_ff @(posedge CLOCK or posedge RESET) begin
            if (RESET) begin
                chan_reg[c] <= '0;
                rise_snapshot_reg[c] <= ccc_pkg::SNAP_RESET;
                fall_snapshot_reg[c] <= ccc_pkg::SNAP_RESET;
                irq_reg[c] <= 1'b0;
            end else begin
                chan_reg[c] <= ch_next;
                irq_reg[c] <= rise_irq || fall_irq;
                if (rise) begin
                    rise_snapshot_reg[c] <= COUNTER; // R4 R15
                end
                if (fall) begin
                    fall_snapshot_reg[c] <= COUNTER; // R3 R15
                end
            end
        end

        assign ctrl_view[B +: 16] = {8'h00, chan_reg[c].fall_latched, chan_reg[c].rise_latched, 1'b0,
            chan_reg[c].irq_flag, chan_reg[c].capture_enable, chan_reg[c].fall_irq_en,
            chan_reg[c].rise_irq_en, chan_reg[c].polarity_flip}; // R18
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [31:0] rd_sel;
    always_comb begin
        unique case (bus.addr)
            ccc_pkg::CTRL_OFFSET: rd_sel = ctrl_view;
            ccc_pkg::RISE_CH2_OFFSET: rd_sel = 32'(rise_snapshot_reg[0]); // R16
            ccc_pkg::FALL_CH2_OFFSET: rd_sel = 32'(fall_snapshot_reg[0]); // R16
            ccc_pkg::RISE_CH3_OFFSET: rd_sel = 32'(rise_snapshot_reg[1]); // R16
            ccc_pkg::FALL_CH3_OFFSET: rd_sel = 32'(fall_snapshot_reg[1]); // R16
            default: rd_sel = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            RDATA <= ccc_pkg::CTRL_RESET;
        end else begin
            RDATA <= bus.rd ? rd_sel : 32'h0000_0000;
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            CAPTURE_IRQ_FLAG <= 2'h0;
            CAPTURE_IRQ <= 2'h0;
        end else begin
            CAPTURE_IRQ_FLAG <= {ch_flag(chan_reg[1]), ch_flag(chan_reg[0])};
            CAPTURE_IRQ <= irq_reg;
        end
    end

    function automatic logic ch_flag(input ccc_pkg::ccc_chan_type ch);
        return ch.irq_flag;
    endfunction

endmodule
